// >>> design/cdcp_pin_mux.sv
// Control-pin front end: interface select, pin decode, straps, detect line
//
// How it works
// R1 - floating mode pin SPI, low SMBus
// R2 - second cable driver off when pin high
// R3 - slew pin sets edge rate, both drivers
// R4 - slew pin also sets pre-emphasis level
// R5 - swing pin picks one of four amplitudes
// R6 - detect line low while input signal valid
// R7 - control bit turns detect into interrupt
// R8 - enable high runs, low powers down
// R9 - enable pin pulled up, default enabled
// R10 - SPI frames only while select held low
// R11 - master drives clock and data in
// R12 - read data returned on master-in line
// R13 - SMBus straps latched once, sixteen addresses
// R14 - SMBus clock is only an input
// R15 - shared pins change role with interface
// R16 - loopback output off when pin high
`timescale 1ns/1ps
`default_nettype none
`include "cdcp_defs.svh"
module cdcp_pin_mux
  import cdcp_pkg::*;
#(
  parameter logic [6:0] SMB_ADDR_BASE = `CDCP_SMB_BASE
) (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Four-level pin codes from the comparators
  input  wire logic [1:0]  modeSelect,
  input  wire logic [1:0]  edgeRateSelect,
  input  wire logic [1:0]  cableSwingSelect,
  input  wire logic [1:0]  addrStrapLo,
  input  wire logic [1:0]  addrStrapHi,
  // Two-level control pins
  input  wire logic        enable,
  input  wire logic        cableOut2EnableN,
  input  wire logic        loopbackOutEnableN,
  input  wire logic        hostDiffInput,
  // Shared serial pins
  input  wire logic        serialClk,
  input  wire logic        slaveSelectN,
  input  wire logic        dataIn,
  output logic             dataOut,
  output logic             dataOe,
  output logic             misoOut,
  output logic             misoOe,
  // Detect line, open drain
  output logic             signalDetectNOut,
  output logic             signalDetectNOe,
  // From the control registers, same clock
  input  wire logic        sdIntMode,
  input  wire logic        intRequestN,
  input  wire logic        smbSdaDriveLow,
  // Decoded settings
  output logic             powerDown,
  output logic             out2DriverOn,
  output logic             loopbackDriverOn,
  output logic [1:0]       edgeRate,
  output logic [1:0]       preEmphasis,
  output logic [1:0]       cableSwing,
  // Interface state
  output logic             spiMode,
  output logic             smbusMode,
  output logic [6:0]       smbAddress,
  output logic             smbAddressValid,
  output logic             smbSclIn,
  output logic             smbSdaIn,
  // Register writes from SPI frames
  output logic             regWrite,
  output logic [6:0]       regAddr,
  output logic [7:0]       regWdata
);

  // Index 0..3 of a four-level code, ordered L, R, F, H
  function automatic logic [1:0] levelIdx(input cdcp_level_t lvl);
    logic [1:0] idx;
    idx = 2'h0;
    unique case (lvl)
      `CDCP_LVL_L: idx = 2'h0;
      `CDCP_LVL_R: idx = 2'h1;
      `CDCP_LVL_F: idx = 2'h2;
      `CDCP_LVL_H: idx = 2'h3;
    endcase
    return idx;
  endfunction

  logic [`CDCP_PIN_WIDTH-1:0] pinRaw;
  logic [`CDCP_PIN_WIDTH-1:0] pinSync;
  cdcp_level_t                modeS;
  cdcp_level_t                edgeS;
  cdcp_level_t                swingS;
  cdcp_level_t                strapLoS;
  cdcp_level_t                strapHiS;
  logic                       enableS;
  logic                       out2NS;
  logic                       loopNS;
  logic                       detectS;
  logic                       ssS;
  logic                       sdaS;
  logic                       sclS;
  logic                       linkToggle;
  logic [14:0]                linkWord;
  logic                       toggleS;
  logic                       toggleSeen;
  logic [7:0]                 statusHold;
  logic [3:0]                 strapCount;
  cdcp_strap_st_t             strapState;
  logic [3:0]                 strapIndex;

  // Every pin is asynchronous here, so all of them pass two flops
  assign pinRaw = {modeSelect, edgeRateSelect, cableSwingSelect, addrStrapLo, addrStrapHi,
                   enable, cableOut2EnableN, loopbackOutEnableN, hostDiffInput,
                   slaveSelectN, dataIn, serialClk};

  // Reset image mirrors the pull-ups: enabled, both extra drivers off
  cdcp_sync #(
    .WIDTH   (`CDCP_PIN_WIDTH),
    .RST_VAL (`CDCP_PIN_RST)
  ) u_pin_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (pinRaw),
    .dout (pinSync)
  );

  // Named views of the synchronised bundle
  assign modeS    = pinSync[16:15];
  assign edgeS    = pinSync[14:13];
  assign swingS   = pinSync[12:11];
  assign strapLoS = pinSync[10:9];
  assign strapHiS = pinSync[8:7];
  assign enableS  = pinSync[6];
  assign out2NS   = pinSync[5];
  assign loopNS   = pinSync[4];
  assign detectS  = pinSync[3];
  assign ssS      = pinSync[2];
  assign sdaS     = pinSync[1];
  assign sclS     = pinSync[0];

  // Interface select; the other two levels leave both interfaces off
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      spiMode   <= 1'b0;
      smbusMode <= 1'b0;
    end
    else
    begin
      spiMode   <= (modeS == `CDCP_LVL_F); // R1
      smbusMode <= (modeS == `CDCP_LVL_L); // R1
    end
  end

  // Power and driver enables; power-down overrides the select pins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      powerDown        <= 1'b0;
      out2DriverOn     <= 1'b0;
      loopbackDriverOn <= 1'b0;
    end
    else
    begin
      powerDown        <= !enableS; // R8 R9
      out2DriverOn     <= enableS && !out2NS; // R2
      loopbackDriverOn <= enableS && !loopNS; // R16
    end
  end

  // Edge rate and pre-emphasis both follow the slew pin; rate checks downstream
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      edgeRate    <= 2'h0;
      preEmphasis <= 2'h0;
      cableSwing  <= 2'h0;
    end
    else
    begin
      edgeRate    <= levelIdx(edgeS); // R3
      preEmphasis <= levelIdx(edgeS); // R4
      cableSwing  <= levelIdx(swingS); // R5
    end
  end

  // Detect line only ever pulls low; enable high means pulling
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      signalDetectNOut <= 1'b0;
      signalDetectNOe  <= 1'b0;
    end
    else
    begin
      signalDetectNOut <= 1'b0;
      if (sdIntMode)
        signalDetectNOe <= !intRequestN; // R7
      else
        signalDetectNOe <= detectS; // R6
    end
  end

  // Straps are read once, after the synchroniser has settled
  assign strapIndex = {levelIdx(strapHiS), levelIdx(strapLoS)};

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strapState      <= ST_WAIT;
      strapCount      <= 4'h0;
      smbAddress      <= 7'h00;
      smbAddressValid <= 1'b0;
    end
    else
    begin
      unique case (strapState)
        ST_WAIT:
        begin
          if (strapCount == `CDCP_STRAP_WAIT)
          begin
            strapState <= ST_TAKEN;
            if (modeS == `CDCP_LVL_L)
            begin
              smbAddress      <= 7'(SMB_ADDR_BASE + {3'h0, strapIndex}); // R13 R15
              smbAddressValid <= 1'b1; // R13
            end
          end
          else
            strapCount <= strapCount + 4'h1;
        end
        ST_TAKEN:
          strapState <= ST_TAKEN; // R13
      endcase
    end
  end

  // SMBus pins as seen by the bus engine; idle high outside SMBus mode
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      smbSclIn <= 1'b1;
      smbSdaIn <= 1'b1;
      dataOut  <= 1'b0;
      dataOe   <= 1'b0;
    end
    else
    begin
      smbSclIn <= smbusMode ? sclS : 1'b1; // R14 R15
      smbSdaIn <= smbusMode ? sdaS : 1'b1; // R15
      dataOut  <= 1'b0;
      dataOe   <= smbusMode && smbSdaDriveLow; // R15
    end
  end

  // Master-in pin driven only in SPI mode inside a frame; strap pin otherwise
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      misoOe <= 1'b0;
    else
      misoOe <= spiMode && !ssS; // R10 R12 R15
  end

  // Status snapshot frozen during a frame so the link reads a stable word
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      statusHold <= 8'h00;
    else if (ssS)
    begin
      statusHold                  <= 8'h00;
      statusHold[`CDCP_ST_SPI]    <= spiMode;
      statusHold[`CDCP_ST_SMB]    <= smbusMode;
      statusHold[`CDCP_ST_DETECT] <= detectS;
      statusHold[`CDCP_ST_ENABLE] <= enableS;
      statusHold[`CDCP_ST_OUT2]   <= out2DriverOn;
      statusHold[`CDCP_ST_LOOP]   <= loopbackDriverOn;
      statusHold[`CDCP_ST_STRAPS] <= (strapState == ST_TAKEN);
    end
  end

  // Serial-clock domain of the SPI slave
  cdcp_spi_link u_spi_link (
    .serialClk    (serialClk),
    .nrst         (nrst),
    .slaveSelectN (slaveSelectN),
    .mosi         (dataIn),
    .misoOut      (misoOut),
    .statusByte   (statusHold),
    .wrToggle     (linkToggle),
    .wrWord       (linkWord)
  );

  // Write toggle crosses by two flops; the word changes on the same serial edge as the toggle and is stable before the toggle is seen
  cdcp_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b0)
  ) u_toggle_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (linkToggle),
    .dout (toggleS)
  );

  // One-cycle write strobe per completed write frame, SPI mode only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      toggleSeen <= 1'b0;
      regWrite   <= 1'b0;
      regAddr    <= 7'h00;
      regWdata   <= 8'h00;
    end
    else
    begin
      toggleSeen <= toggleS;
      regWrite   <= 1'b0;
      if (toggleS != toggleSeen && spiMode)
      begin
        regWrite <= 1'b1; // R10 R11
        regAddr  <= linkWord[14:8];
        regWdata <= linkWord[7:0];
      end
    end
  end

  // Checks on the system clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_MODE_SPI: assert property ((modeS == `CDCP_LVL_F) |=> spiMode && !smbusMode) // R1
    else $error("floating mode pin did not select SPI");
  AST_MODE_SMB: assert property ((modeS == `CDCP_LVL_L) |=> smbusMode && !spiMode) // R1
    else $error("low mode pin did not select SMBus");
  AST_OUT2_OFF: assert property ($rose(out2NS) |=> !out2DriverOn ##1 !out2DriverOn) // R2
    else $error("second cable driver on with select pin high");
  AST_SLEW_TIE: assert property ($stable(edgeS)[*2] |-> edgeRate == preEmphasis && edgeRate == levelIdx(edgeS)) // R3
    else $error("edge rate and pre-emphasis disagree with slew pin");
  AST_SWING: assert property (swingS == `CDCP_LVL_H |=> cableSwing == 2'h3) // R5
    else $error("swing setting does not follow amplitude pin");
  AST_DETECT: assert property ((!sdIntMode && detectS) |=> signalDetectNOe && !signalDetectNOut) // R6
    else $error("detect line not pulled while signal present");
  AST_INT_MODE: assert property (sdIntMode |=> signalDetectNOe == !$past(intRequestN)) // R7
    else $error("interrupt mode does not follow interrupt request");
  AST_POWER_DOWN: assert property (!enableS |=> powerDown && !out2DriverOn && !loopbackDriverOn) // R8
    else $error("low enable did not power down");
  AST_LOOP_OFF: assert property (loopNS |=> !loopbackDriverOn) // R16
    else $error("loopback output on with select pin high");
  AST_STRAP_ONCE: assert property (smbAddressValid |=> smbAddressValid && $stable(smbAddress)) // R13
    else $error("strap address changed after capture");
  AST_WRITE_SPI: assert property (regWrite |-> spiMode ##1 !regWrite) // R10
    else $error("register write outside SPI mode or longer than one cycle");
  AST_MISO_FRAME: assert property (misoOe |-> $past(spiMode) && !$past(ssS)) // R12
    else $error("master-in pin driven outside an SPI frame");

endmodule // cdcp_pin_mux
`default_nettype wire

// >>> design/cdcp_defs.svh
// Constants for the cable driver control-pin front end
`ifndef CDCP_DEFS_SVH
`define CDCP_DEFS_SVH

// Four-level pin codes as delivered by the level comparators
`define CDCP_LVL_L        2'h0
`define CDCP_LVL_R        2'h1
`define CDCP_LVL_F        2'h2
`define CDCP_LVL_H        2'h3

// Synchroniser depth and reset image of the pin bundle
`define CDCP_SYNC_STAGES  2
`define CDCP_PIN_WIDTH    17
`define CDCP_PIN_RST      17'h10077

// Cycles after reset release before the straps are taken
`define CDCP_STRAP_WAIT   4'h4

// Default base of the sixteen strap-selected SMBus addresses
`define CDCP_SMB_BASE     7'h10

// Serial frame layout: read flag, 7 address bits, 8 data bits
`define CDCP_SPI_LAST     5'h0f
`define CDCP_SPI_FULL     5'h10
`define CDCP_SPI_DATA_AT  5'h08

// Status byte bit positions returned on a serial read
`define CDCP_ST_SPI       7
`define CDCP_ST_SMB       6
`define CDCP_ST_DETECT    5
`define CDCP_ST_ENABLE    4
`define CDCP_ST_OUT2      3
`define CDCP_ST_LOOP      2
`define CDCP_ST_STRAPS    1

`endif

// >>> design/cdcp_pkg.sv
// Types shared by the control-pin front end
package cdcp_pkg;

  // Code of a four-level pin
  typedef logic [1:0] cdcp_level_t;

  // Strap capture sequence
  typedef enum logic [1:0] {
    ST_WAIT,
    ST_TAKEN
  } cdcp_strap_st_t;

endpackage

// >>> design/cdcp_sync.sv
// Two-flop synchroniser for a bundle of quasi-static pin levels
`timescale 1ns/1ps
`default_nettype none
module cdcp_sync #(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Levels in and out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= RST_VAL;
      dout   <= RST_VAL;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // cdcp_sync
`default_nettype wire

// >>> design/cdcp_spi_link.sv
// Serial-clock side of the SPI slave: shifter, write toggle, read shift-out
`timescale 1ns/1ps
`default_nettype none
`include "cdcp_defs.svh"
module cdcp_spi_link (
  // Link clock and resets
  input  wire logic        serialClk,
  input  wire logic        nrst,
  input  wire logic        slaveSelectN,
  // Serial data
  input  wire logic        mosi,
  output logic             misoOut,
  // Crossing to the system clock
  input  wire logic [7:0]  statusByte,
  output logic             wrToggle,
  output logic [14:0]      wrWord
);

  logic [4:0]  bitCount;
  logic [15:0] shiftIn;
  logic [7:0]  shiftOut;

  // Frame counter; a high select ends the frame even if the clock stops
  always_ff @(posedge serialClk or negedge nrst or posedge slaveSelectN)
  begin
    if (!nrst)
      bitCount <= 5'h00;
    else if (slaveSelectN)
      bitCount <= 5'h00; // R10
    else if (bitCount != `CDCP_SPI_FULL)
      bitCount <= bitCount + 5'h01;
  end

  // Input shifter, MSB first; bits past the sixteenth are ignored
  always_ff @(posedge serialClk or negedge nrst)
  begin
    if (!nrst)
      shiftIn <= 16'h0000;
    else if (!slaveSelectN && bitCount != `CDCP_SPI_FULL)
      shiftIn <= {shiftIn[14:0], mosi}; // R11
  end

  // Completed write frame: word loaded and toggle flipped on the same serial clock edge
  always_ff @(posedge serialClk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrToggle <= 1'b0;
      wrWord   <= 15'h0000;
    end
    else if (!slaveSelectN && bitCount == `CDCP_SPI_LAST && !shiftIn[14])
    begin
      wrWord   <= {shiftIn[13:0], mosi};
      wrToggle <= ~wrToggle;
    end
  end

  // Read data leaves on the falling edge so the master samples it rising
  always_ff @(negedge serialClk or negedge nrst)
  begin
    if (!nrst)
    begin
      misoOut  <= 1'b0;
      shiftOut <= 8'h00;
    end
    else if (bitCount == `CDCP_SPI_DATA_AT)
    begin
      misoOut  <= statusByte[7]; // R12
      shiftOut <= {statusByte[6:0], 1'b0};
    end
    else if (bitCount > `CDCP_SPI_DATA_AT && bitCount < `CDCP_SPI_FULL)
    begin
      misoOut  <= shiftOut[7]; // R12
      shiftOut <= {shiftOut[6:0], 1'b0};
    end
  end

endmodule // cdcp_spi_link
`default_nettype wire

// >>> testbench/cdcp_host_model.sv
// Behavioural host: SPI master and SMBus pin driver on the shared serial pins
`timescale 1ns/1ps
`default_nettype none
module cdcp_host_model (
  // Shared serial pins towards the device
  output var logic serialClk,
  output var logic slaveSelectN,
  output var logic mosi,
  // Master-in pin as resolved on the board
  input  wire logic misoPin
);
  // Idle: clock parked low, select released high
  initial
  begin
    serialClk    = 1'b0;
    slaveSelectN = 1'b1;
    mosi         = 1'b1;
  end

  // One frame MSB first; fewer than 16 edges aborts it
  // Clock runs only inside the frame, 32 ns period
  task automatic frame(input logic [15:0] w, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    #3;
    slaveSelectN = 1'b0;
    #80;
    for (int i = 0; i < nb; i++)
    begin
      mosi = w[15-i];
      #16 serialClk = 1'b1;
      if (i >= 8)
        rd[15-i] = misoPin;
      #16 serialClk = 1'b0;
    end
    #20 slaveSelectN = 1'b1;
    mosi = ~mosi; // Released line must not keep the last bit
  endtask

  // Static SMBus levels; clock comes from the host only
  task automatic bus_pins(input logic scl, input logic sda);
    serialClk = scl;
    mosi      = sda;
  endtask
endmodule // cdcp_host_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the control-pin front end
`timescale 1ns/1ps
`default_nettype none
`include "cdcp_defs.svh"
module tb_top
  import cdcp_pkg::*;
();
  logic        clk, nrst, enable, out2N, loopN, hostDiff, sdIntMode, intReqN, sdaLow;
  cdcp_level_t modeSel, edgeSel, swingSel, strapLo, strapHi;
  wire logic   sck, ssN, mosi, dataOut, dataOe, misoOut, misoOe, sdOut, sdOe;
  wire logic   powerDown, out2On, loopOn, spiMode, smbusMode, addrValid, sclIn, sdaIn, regWrite;
  wire logic [1:0] edgeRate, preEmph, swing;
  wire logic [6:0] smbAddr, regAddr;
  wire logic [7:0] regWdata;
  // Open-drain SDA with pull-up; master-in pin pulled up when undriven
  wire logic   dataPin = mosi & ~dataOe;
  wire logic   misoPin = misoOe ? misoOut : 1'b1;
  int          bad_count, compares, cycles;
  logic [7:0]  rd;
  logic [15:0] wr [3] = '{16'h2ac5, 16'h7f00, 16'h0f81};
  bit          hit;

  cdcp_pin_mux dut_u (
    .clk(clk), .nrst(nrst), .modeSelect(modeSel), .edgeRateSelect(edgeSel),
    .cableSwingSelect(swingSel), .addrStrapLo(strapLo), .addrStrapHi(strapHi),
    .enable(enable), .cableOut2EnableN(out2N), .loopbackOutEnableN(loopN),
    .hostDiffInput(hostDiff), .serialClk(sck), .slaveSelectN(ssN), .dataIn(dataPin),
    .dataOut(dataOut), .dataOe(dataOe), .misoOut(misoOut), .misoOe(misoOe),
    .signalDetectNOut(sdOut), .signalDetectNOe(sdOe), .sdIntMode(sdIntMode),
    .intRequestN(intReqN), .smbSdaDriveLow(sdaLow), .powerDown(powerDown),
    .out2DriverOn(out2On), .loopbackDriverOn(loopOn), .edgeRate(edgeRate),
    .preEmphasis(preEmph), .cableSwing(swing), .spiMode(spiMode), .smbusMode(smbusMode),
    .smbAddress(smbAddr), .smbAddressValid(addrValid), .smbSclIn(sclIn), .smbSdaIn(sdaIn),
    .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata)
  );

  cdcp_host_model host_u (
    .serialClk(sck), .slaveSelectN(ssN), .mosi(mosi), .misoPin(misoPin)
  );

  // 100 MHz system clock
  always #5 clk = ~clk;

  // Hang guard: whole run needs well under 2000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      final_report();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Reset held 5 cycles, then time for sync and strap capture
  task automatic do_reset();
    nrst = 1'b0;
    step(5);
    nrst = 1'b1;
    step(8);
  endtask

  // Bounded wait for the one-cycle write pulse; runs beside the frame, because the pulse rises before the frame has ended
  task automatic wait_write(output bit h);
    h = 1'b0;
    for (int i = 0; i < 80 && !h; i++)
    begin
      step(1);
      h = (regWrite === 1'b1);
    end
  endtask

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    enable = 1'b1;
    out2N = 1'b1;
    loopN = 1'b1;
    hostDiff = 1'b0;
    sdIntMode = 1'b0;
    intReqN = 1'b1;
    sdaLow = 1'b0;
    modeSel = `CDCP_LVL_F;
    edgeSel = `CDCP_LVL_L;
    swingSel = `CDCP_LVL_L;
    strapLo = `CDCP_LVL_L;
    strapHi = `CDCP_LVL_L;
    do_reset();
    // Pull-up defaults: running, both optional drivers off
    check("powerDown", powerDown, 16'h0);
    check("out2On", out2On, 16'h0);
    check("loopOn", loopOn, 16'h0);
    check("spiMode", spiMode, 16'h1);
    check("smbusMode", smbusMode, 16'h0);
    check("addrValid", addrValid, 16'h0);
    // Every level of the slew and swing pins
    for (int v = 0; v < 4; v++)
    begin
      edgeSel = cdcp_level_t'(v);
      swingSel = cdcp_level_t'(3 - v);
      step(4);
      check("edgeRate", edgeRate, 16'(v));
      check("preEmph", preEmph, 16'(v));
      check("swing", swing, 16'(3 - v));
    end
    // Power-down overrides both driver enables
    enable = 1'b0;
    out2N = 1'b0;
    loopN = 1'b0;
    step(4);
    check("powerDown", powerDown, 16'h1);
    check("out2On", out2On, 16'h0);
    check("loopOn", loopOn, 16'h0);
    enable = 1'b1;
    step(4);
    check("powerDown", powerDown, 16'h0);
    check("out2On", out2On, 16'h1);
    check("loopOn", loopOn, 16'h1);
    loopN = 1'b1;
    // Detect line, then its interrupt role
    hostDiff = 1'b1;
    step(4);
    check("sdOe", sdOe, 16'h1);
    check("sdOut", sdOut, 16'h0);
    hostDiff = 1'b0;
    step(4);
    check("sdOe", sdOe, 16'h0);
    sdIntMode = 1'b1;
    hostDiff = 1'b1;
    step(4);
    check("sdOe", sdOe, 16'h0);
    intReqN = 1'b0;
    step(2);
    check("sdOe", sdOe, 16'h1);
    intReqN = 1'b1;
    sdIntMode = 1'b0;
    hostDiff = 1'b0;
    step(4);
    // Writes, with an aborted frame before the last one
    for (int k = 0; k < 3; k++)
    begin
      if (k == 2)
      begin
        fork
          host_u.frame(16'h1234, 10, rd);
          wait_write(hit);
        join
        check("abortWrite", 16'(hit), 16'h0);
      end
      fork
        host_u.frame(wr[k], 16, rd);
        wait_write(hit);
      join
      check("regWrite", 16'(hit), 16'h1);
      check("regAddr", regAddr, 16'(wr[k][14:8]));
      check("regWdata", regWdata, 16'(wr[k][7:0]));
    end
    // Status read: spi, enable, out2 on, strap window passed
    fork
      host_u.frame(16'h8000, 16, rd);
      begin
        step(12);
        check("misoOe", misoOe, 16'h1);
      end
    join
    check("status", 16'(rd), 16'h009a);
    step(5);
    check("misoOe", misoOe, 16'h0);
    // Released select pin turns the second driver off again
    out2N = 1'b1;
    step(4);
    check("out2On", out2On, 16'h0);
    check("loopOn", loopOn, 16'h0);
    // SMBus: straps taken at power-up only
    modeSel = `CDCP_LVL_L;
    strapLo = `CDCP_LVL_R;
    strapHi = `CDCP_LVL_F;
    do_reset();
    check("smbusMode", smbusMode, 16'h1);
    check("spiMode", spiMode, 16'h0);
    check("addrValid", addrValid, 16'h1);
    check("smbAddr", smbAddr, 16'(`CDCP_SMB_BASE + 7'h09));
    strapLo = `CDCP_LVL_H;
    step(4);
    check("smbAddr", smbAddr, 16'(`CDCP_SMB_BASE + 7'h09));
    host_u.bus_pins(1'b0, 1'b0);
    step(4);
    check("sclIn", sclIn, 16'h0);
    check("sdaIn", sdaIn, 16'h0);
    host_u.bus_pins(1'b1, 1'b1);
    step(4);
    check("sclIn", sclIn, 16'h1);
    check("sdaIn", sdaIn, 16'h1);
    sdaLow = 1'b1;
    step(3);
    check("dataOe", dataOe, 16'h1);
    check("dataOut", dataOut, 16'h0);
    sdaLow = 1'b0;
    // SPI traffic has no effect in SMBus mode
    host_u.bus_pins(1'b0, 1'b1);
    fork
      host_u.frame(16'h2ac5, 16, rd);
      wait_write(hit);
      begin
        step(12);
        check("misoOe", misoOe, 16'h0);
      end
    join
    check("smbWrite", 16'(hit), 16'h0);
    check("misoOe", misoOe, 16'h0);
    // Unused mode level selects neither interface
    modeSel = `CDCP_LVL_H;
    step(4);
    check("spiMode", spiMode, 16'h0);
    check("smbusMode", smbusMode, 16'h0);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
